// ==== hdl/timer_program_pwm_engine.sv ====
// Linked-instruction timer engine with program RAM, AXI4-Lite slave, 4 pins.
// Assumes one clock, an AXI4-Lite master and software that loads the RAM.
`timescale 1ns/1ps
`include "timer_program_map.svh"
module timer_program_pwm_engine
  import timer_program_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [3:0] o_pin
);
  // The RAM has no reset; software must load it before setting run.
  logic [31:0] mem [0:`TP_MEM_DEPTH-1];
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
  logic [11:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata, host_word;
  logic do_write, host_mem_we;
  logic [5:0] host_idx;
  logic [6:0] lp_ff, nxt_lp, lp_last;
  logic cont_ff, nxt_cont;
  instr_addr_t pc_ff, nxt_pc, cur;
  lr_value_t reg_ff [0:1];
  lr_value_t nxt_reg [0:1];
  logic [3:0] pin_ff, nxt_pin, armed_ff, nxt_armed, pend_ff, nxt_pend;
  logic [6:0] dly_ff [0:3];
  logic [6:0] nxt_dly [0:3];
  logic run, active, is_count, is_cmp, wrap, match, fire, eng_we;
  logic [31:0] prog, ctl, dat;
  opcode_t opc;
  lr_value_t regv, count_new;
  logic [6:0] delay;
  logic [5:0] eng_idx;

  assign run = ctrl_ff[`TP_CTL_RUN];

  always_comb
  begin
    lp_last = 7'((8'h1 << ctrl_ff[`TP_CTL_LR]) - 8'h1);
    active = run & ((lp_ff == 7'h0) | cont_ff);
    cur = (lp_ff == 7'h0) ? `TP_START : pc_ff;
    prog = mem[{cur, `TP_FLD_PROG}];
    ctl = mem[{cur, `TP_FLD_CTRL}];
    dat = mem[{cur, `TP_FLD_DATA}];
    opc = opcode_t'(prog[`TP_OPC]);
    is_count = 1'b0;
    is_cmp = 1'b0;
    unique case (opc)
      op_virtual_count: is_count = active;
      op_magnitude_compare: is_cmp = active;
      default: is_count = 1'b0;
    endcase
    wrap = dat[`TP_LR] >= ctl[`TP_MAX];
    count_new = wrap ? 25'h0 : dat[`TP_LR] + 25'h1;
    eng_we = is_count;
    eng_idx = {cur, `TP_FLD_DATA};
    regv = reg_ff[prog[`TP_RSEL]];
    // Order bit low asks for plain equality.
    match = ctl[`TP_ORDER] ? (regv >= dat[`TP_LR]) :
      (regv == dat[`TP_LR]);
    fire = is_cmp & match & ctl[`TP_PIN_EN] &
      (ctl[`TP_ACT] == `TP_ACT_PULSE_HIGH);
    // Low bits finer than one clock are shifted away and ignored.
    delay = ctl[`TP_RES_SEL] ?
      (dat[`TP_HR] >> (`TP_HR_TOP - ctrl_ff[`TP_CTL_LR])) : 7'h0;
    nxt_cont = active & (prog[`TP_NEXT] != `TP_START) &
      (lp_ff != lp_last);
    nxt_pc = active ? prog[`TP_NEXT] : pc_ff;
    nxt_lp = (!run || lp_ff == lp_last) ? 7'h0 : lp_ff + 7'h1;
    nxt_reg[0] = reg_ff[0];
    nxt_reg[1] = reg_ff[1];
    if (is_count)
    begin
      nxt_reg[prog[`TP_RSEL]] = count_new;
    end
  end

  always_comb
  begin
    nxt_pin = pin_ff;
    nxt_armed = armed_ff;
    nxt_pend = pend_ff;
    for (int i = 0; i < 4; i++)
    begin
      nxt_dly[i] = dly_ff[i];
      if (is_count && wrap && armed_ff[i])
      begin
        nxt_pin[i] = 1'b0;
      end
      if (pend_ff[i])
      begin
        if (dly_ff[i] == 7'h0)
        begin
          nxt_pin[i] = 1'b1;
          nxt_pend[i] = 1'b0;
        end
        else
        begin
          nxt_dly[i] = dly_ff[i] - 7'h1;
        end
      end
      if (fire && ctl[`TP_PIN] == 2'(i))
      begin
        nxt_armed[i] = 1'b1;
        if (delay == 7'h0)
        begin
          nxt_pin[i] = 1'b1;
        end
        else
        begin
          nxt_pend[i] = 1'b1;
          nxt_dly[i] = delay - 7'h1;
        end
      end
      if (!run)
      begin
        nxt_pin[i] = 1'b0;
        nxt_armed[i] = 1'b0;
        nxt_pend[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      lp_ff <= 7'h0;
      cont_ff <= 1'b0;
      pc_ff <= `TP_START;
      reg_ff[0] <= 25'h0;
      reg_ff[1] <= 25'h0;
      pin_ff <= 4'h0;
      armed_ff <= 4'h0;
      pend_ff <= 4'h0;
      for (int i = 0; i < 4; i++)
        dly_ff[i] <= 7'h0;
    end
    else
    begin
      lp_ff <= nxt_lp;
      cont_ff <= nxt_cont;
      pc_ff <= nxt_pc;
      reg_ff[0] <= nxt_reg[0];
      reg_ff[1] <= nxt_reg[1];
      pin_ff <= nxt_pin;
      armed_ff <= nxt_armed;
      pend_ff <= nxt_pend;
      for (int i = 0; i < 4; i++)
        dly_ff[i] <= nxt_dly[i];
    end
  end

  always_comb
  begin
    nxt_aw_held = aw_held_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_held = w_held_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff & ~i_bready;
    nxt_bresp = bresp_ff;
    nxt_ctrl = ctrl_ff;
    host_mem_we = 1'b0;
    host_idx = awaddr_ff[7:2];
    host_word = mem[host_idx];
    if (awready_ff && i_awvalid)
    begin
      nxt_aw_held = 1'b1;
      nxt_awaddr = i_awaddr;
    end
    if (wready_ff && i_wvalid)
    begin
      nxt_w_held = 1'b1;
      nxt_wdata = i_wdata;
      nxt_wstrb = i_wstrb;
    end
    do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
    for (int b = 0; b < 4; b++)
      if (wstrb_ff[b])
        host_word[8*b +: 8] = wdata_ff[8*b +: 8];
    if (do_write)
    begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `TP_RESP_OK;
      if (awaddr_ff[11:8] == `TP_MEM_REGION)
        host_mem_we = 1'b1;
      else if (awaddr_ff == `TP_CTRL_OFF)
        nxt_ctrl = {28'h0, host_word[3:0]};
      else if (awaddr_ff != `TP_STAT_OFF)
        nxt_bresp = `TP_RESP_ERR;
    end
    nxt_awready = ~nxt_aw_held;
    nxt_wready = ~nxt_w_held;
    nxt_rvalid = rvalid_ff & ~i_rready;
    nxt_arready = arready_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && i_rready)
      nxt_arready = 1'b1;
    if (arready_ff && i_arvalid)
    begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rresp = `TP_RESP_OK;
      if (i_araddr[11:8] == `TP_MEM_REGION)
        nxt_rdata = mem[i_araddr[7:2]];
      else if (i_araddr == `TP_CTRL_OFF)
        nxt_rdata = ctrl_ff;
      else if (i_araddr == `TP_STAT_OFF)
        nxt_rdata = {20'h0, pc_ff, 3'h0, active, pin_ff};
      else
      begin
        nxt_rdata = 32'h0;
        nxt_rresp = `TP_RESP_ERR;
      end
    end
  end

  // A host write and a count update to one word in one cycle: host wins.
  always_ff @(posedge i_clk)
  begin
    if (host_mem_we)
      mem[host_idx] <= host_word;
    if (eng_we && !(host_mem_we && host_idx == eng_idx))
      mem[eng_idx] <= {count_new, dat[`TP_HR]};
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 12'h0;
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= `TP_RESP_OK;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `TP_RESP_OK;
      ctrl_ff <= `TP_CTL_RST;
    end
    else
    begin
      aw_held_ff <= nxt_aw_held;
      awaddr_ff <= nxt_awaddr;
      w_held_ff <= nxt_w_held;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign o_awready = awready_ff;
  assign o_wready = wready_ff;
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;
  assign o_arready = arready_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;
  assign o_pin = pin_ff;

  property p_link_follow;
    @(posedge i_clk) disable iff (i_sys_rst)
    nxt_cont |=> (cur == $past(prog[`TP_NEXT])) && active;
  endproperty
  a_link_follow: assert property (p_link_follow)
    else $error("Next instruction did not follow the link.");

  property p_loop_start;
    @(posedge i_clk) disable iff (i_sys_rst)
    (run && lp_ff == 7'h0) |-> active && cur == `TP_START;
  endproperty
  a_loop_start: assert property (p_loop_start)
    else $error("Loop period did not start the chain at zero.");

  property p_count_inc;
    @(posedge i_clk) disable iff (i_sys_rst)
    (is_count && !wrap && !host_mem_we) |=>
      reg_ff[$past(prog[`TP_RSEL])] == $past(dat[`TP_LR]) + 25'h1;
  endproperty
  a_count_inc: assert property (p_count_inc)
    else $error("Virtual count did not add one.");

  property p_count_wrap;
    @(posedge i_clk) disable iff (i_sys_rst)
    (is_count && wrap) |=> reg_ff[$past(prog[`TP_RSEL])] == 25'h0;
  endproperty
  a_count_wrap: assert property (p_count_wrap)
    else $error("Virtual count did not return to zero at maximum.");

  property p_no_action;
    @(posedge i_clk) disable iff (i_sys_rst)
    (is_cmp && !ctl[`TP_PIN_EN] && pend_ff == 4'h0) |=>
      (o_pin & ~$past(o_pin)) == 4'h0;
  endproperty
  a_no_action: assert property (p_no_action)
    else $error("Pin action fired while disabled.");

  property p_ge_match;
    @(posedge i_clk) disable iff (i_sys_rst)
    (is_cmp && ctl[`TP_ORDER] && regv >= dat[`TP_LR] && ctl[`TP_PIN_EN]
      && ctl[`TP_ACT] == `TP_ACT_PULSE_HIGH && delay == 7'h0)
      |=> o_pin[$past(ctl[`TP_PIN])];
  endproperty
  a_ge_match: assert property (p_ge_match)
    else $error("Register-at-least match did not raise the pin.");

  property p_wrap_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
    (is_count && wrap && armed_ff[0] && !pend_ff[0]) |=> !o_pin[0];
  endproperty
  a_wrap_clear: assert property (p_wrap_clear)
    else $error("Pulse pin not cleared on counter wrap.");

  property p_fine_delay;
    @(posedge i_clk) disable iff (i_sys_rst || !run)
    (pend_ff[0] && dly_ff[0] != 7'h0) |=> dly_ff[0] == $past(dly_ff[0]) - 7'h1
      && !$rose(o_pin[0]);
  endproperty
  a_fine_delay: assert property (p_fine_delay)
    else $error("Fine delay did not count down.");

  property p_delay_fits;
    @(posedge i_clk) disable iff (i_sys_rst)
    is_cmp |-> delay <= lp_last;
  endproperty
  a_delay_fits: assert property (p_delay_fits)
    else $error("Fine delay exceeds one loop period.");
endmodule

// ==== hdl/timer_program_map.svh ====
// Address map, field positions and reset values of the timer program engine.
// Assumes inclusion by bare name from the design module.
`ifndef TIMER_PROGRAM_MAP_SVH
`define TIMER_PROGRAM_MAP_SVH
`define TP_MEM_DEPTH 64
`define TP_MEM_REGION 4'h0
`define TP_CTRL_OFF 12'h100
`define TP_STAT_OFF 12'h104
`define TP_FLD_PROG 2'h0
`define TP_FLD_CTRL 2'h1
`define TP_FLD_DATA 2'h2
`define TP_NEXT 3:0
`define TP_OPC 7:4
`define TP_RSEL 8
`define TP_MAX 24:0
`define TP_PIN_EN 0
`define TP_RES_SEL 1
`define TP_PIN 3:2
`define TP_ACT 5:4
`define TP_ORDER 6
`define TP_LR 31:7
`define TP_HR 6:0
`define TP_CTL_RUN 0
`define TP_CTL_LR 3:1
`define TP_CTL_RST 32'h0000_0006
`define TP_ACT_PULSE_HIGH 2'h1
`define TP_RESP_OK 2'h0
`define TP_RESP_ERR 2'h2
`define TP_HR_TOP 3'h7
`define TP_START 4'h0
`endif

// ==== hdl/timer_program_pkg.sv ====
// Types shared by the timer program engine.
// Assumes the map header is on the include path.
package timer_program_pkg;
  typedef enum logic [3:0] {
    op_virtual_count = 4'b0000,
    op_magnitude_compare = 4'b0001
  } opcode_t;
  typedef logic [24:0] lr_value_t;
  typedef logic [3:0] instr_addr_t;
endpackage

// ==== test/pwm_pin_monitor.sv ====
// Observer of one output pin, as the circuit on the pin would see it.
// Assumes a clean level that changes only at rising edges of i_clk.
`timescale 1ns/1ps
module pwm_pin_monitor
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_pin,
  output logic [15:0] o_period,
  output logic [15:0] o_high
);
  logic pin_ff, nxt_pin;
  logic [15:0] count_ff, nxt_count;
  logic [15:0] period_ff, nxt_period;
  logic [15:0] high_ff, nxt_high;
  assign o_period = period_ff;
  assign o_high = high_ff;
  always_comb
  begin
    nxt_pin = i_pin;
    nxt_count = count_ff + 16'h1;
    nxt_period = period_ff;
    nxt_high = high_ff;
    if (i_pin && !pin_ff)
    begin
      nxt_period = count_ff;
      nxt_count = 16'h1;
    end
    if (!i_pin && pin_ff)
      nxt_high = count_ff;
  end
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pin_ff <= 1'b0;
      count_ff <= 16'h0;
      period_ff <= 16'h0;
      high_ff <= 16'h0;
    end
    else
    begin
      pin_ff <= nxt_pin;
      count_ff <= nxt_count;
      period_ff <= nxt_period;
      high_ff <= nxt_high;
    end
  end
endmodule

// ==== test/tb.sv ====
// Bench for the timer program engine, driven over its register bus.
// Assumes a 20 MHz clock and the pin observer on output pin zero.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, r;
  logic [3:0] pins, seen;
  logic [15:0] period, high, h0;
  int failures = 0, checks_done = 0, cycles = 0;
  always #25 clk = ~clk;
  timer_program_pwm_engine timer_program_pwm_engine_i (.i_clk(clk),
    .i_sys_rst(sys_rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_pin(pins));
  pwm_pin_monitor pwm_pin_monitor_i (.i_clk(clk), .i_sys_rst(sys_rst),
    .i_pin(pins[0]), .o_period(period), .o_high(high));
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  // Address and data go out together; each is dropped as it is taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] exp);
    logic aw, w;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w)
    begin
      @(posedge clk);
      if (aw && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clk);
    bready <= 1'b0;
    check("bresp", exp, bresp);
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] exp,
                    output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge clk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge clk);
    d = rdata;
    rready <= 1'b0;
    check("rresp", exp, rresp);
  endtask
  task automatic watch(input int n);
    seen = 4'h0;
    repeat (n)
    begin
      @(posedge clk);
      seen = seen | pins;
    end
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      results();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(12'h100, 2'h0, r);
    check("ctrl reset", 32'h6, r);
    rd(12'h104, 2'h0, r);
    check("pins reset", 32'h0, {28'h0, r[3:0]});
    rd(12'h200, 2'h2, r);
    check("unmapped read", 32'h0, r);
    wr(12'h200, 32'h1, 2'h2);
    $display("test reset done");
    // Count at slot 0, compare at slot 5, so the link is really followed.
    wr(12'h000, 32'h5, 2'h0);
    wr(12'h004, 32'h9, 2'h0);
    wr(12'h008, 32'h0, 2'h0);
    wr(12'h050, 32'h10, 2'h0);
    wr(12'h054, 32'h53, 2'h0);
    wr(12'h058, {25'd4, 7'h60}, 2'h0);
    wr(12'h05c, 32'ha5a5_0f0f, 2'h0);
    rd(12'h05c, 2'h0, r);
    check("reserved word", 32'ha5a5_0f0f, r);
    // Two instructions fit easily in the eight slots of this prescale.
    wr(12'h100, 32'h7, 2'h0);
    watch(300);
    check("period", 32'd80, period);
    h0 = high;
    // Six matching loops of eight clocks, less one clock and the six-clock fine delay.
    check("pulse high", 32'd41, {16'h0, h0});
    rd(12'h008, 2'h0, r);
    check("count bound", 32'h1, {31'h0, r[31:7] <= 25'd9});
    $display("test pwm done");
    wr(12'h058, {25'd4, 7'h00}, 2'h0);
    watch(200);
    check("no fine delay", h0 + 6, high);
    wr(12'h058, {25'd4, 7'h6f}, 2'h0);
    watch(200);
    check("low fine bits", h0, high);
    wr(12'h058, {25'd5, 7'h60}, 2'h0);
    watch(200);
    check("later compare", h0 - 8, high);
    wr(12'h058, {25'd4, 7'h60}, 2'h0);
    wr(12'h054, 32'h51, 2'h0);
    watch(200);
    check("coarse timing", h0 + 6, high);
    $display("test duty done");
    wr(12'h054, 32'h52, 2'h0);
    watch(200);
    watch(100);
    check("action off", 32'h0, {28'h0, seen});
    wr(12'h054, 32'h5b, 2'h0);
    watch(200);
    watch(100);
    check("pin select", 32'h4, {28'h0, seen});
    $display("test pins done");
    results();
  end
endmodule
